// *** hdl/sfe_core.sv ***
// Erase and deep power-down command core of the serial flash
//
// Notes on behaviour
// - Opcode 52H plus three address bytes erases the 32KB block holding the address.
// - Opcode D8H plus three address bytes erases the 64KB block holding the address.
// - Host sets the write enable latch first; erase starts only while it is set.
// - Block erase counts only if select rises right after the last address byte.
// - Valid erase end starts a timed cycle; busy flag high throughout, then low.
// - Status byte stays readable during an erase so the busy flag can be polled.
// - Write enable latch is cleared before the erase cycle finishes.
// - Block erase of a protected block is not carried out.
// - Chip erase is 60H or C7H alone, ended right after the opcode.
// - Chip erase only when no block is protected by the protect bits.
// - Opcode B9H ended after the opcode enters sleep after the entry delay.
// - Asleep, only ABH or the 66H then 99H pair is obeyed; each wakes.
// - Sleep command arriving during a busy cycle is refused; the cycle continues.
// - Sleep only by its command; deselect gives standby; reset starts in standby.
`timescale 1ns/10ps
module sfe_core
    import sfe_pkg::*;
#(
    parameter int unsigned BLOCK_ERASE_CYC = BLOCK_ERASE_CYCLES,
    parameter int unsigned CHIP_ERASE_CYC  = ARRAY_ERASE_CYCLES
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Serial link pins
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        si,
    output logic             so,
    output logic             so_oe,
    // Protection configuration
    input  wire logic [4:0]  protect_bits,
    input  wire logic        protect_complement_bit,
    // Status
    output logic             write_in_progress_flag,
    output logic             write_enable_latch,
    output logic             deep_sleep,
    output sfe_erase_t       erase_kind,
    output logic [23:0]      erase_addr
);
    sfe_link_if lk ();

    sfe_link_rx u_rx (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cs_n    (cs_n),
        .sclk    (sclk),
        .si      (si),
        .lk      (lk)
    );

    sfe_state_t  state_r, state_nxt;
    sfe_erase_t  kind_r, kind_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [23:0] addr_r, addr_nxt, adr_in_r, adr_in_nxt;
    logic [7:0]  op_r, op_nxt, status_byte;
    logic [6:0]  sh_r, sh_nxt;
    logic        busy_r, busy_nxt, wen_r, wen_nxt, sleep_r, sleep_nxt;
    logic        arm_r, arm_nxt, rd_r, rd_nxt, so_r, so_nxt, oe_r, oe_nxt;
    logic        valid_end, blk_prot, chip_ok, is_block_op;

    assign valid_end   = lk.cs_rise && (lk.bit_cnt == 3'h0);
    assign blk_prot    = sfe_blk_protected(adr_in_r[19:16], protect_bits, protect_complement_bit);
    assign chip_ok     = sfe_chip_erase_ok(protect_bits, protect_complement_bit);
    assign is_block_op = (op_r == OP_ERASE_32K) || (op_r == OP_ERASE_64K);

    always_comb begin
        status_byte             = 8'h00;
        status_byte[ST_BUSY_BIT]    = busy_r;
        status_byte[ST_WEN_BIT]     = wen_r;
        status_byte[ST_BP_LSB +: 5] = protect_bits;
        status_byte[ST_COMPL_BIT]   = protect_complement_bit;
    end

    always_comb begin
        state_nxt  = state_r;
        kind_nxt   = kind_r;
        cnt_nxt    = cnt_r;
        addr_nxt   = addr_r;
        adr_in_nxt = adr_in_r;
        op_nxt     = op_r;
        sh_nxt     = sh_r;
        so_nxt     = so_r;
        busy_nxt   = busy_r;
        wen_nxt    = wen_r;
        sleep_nxt  = sleep_r;
        arm_nxt    = arm_r;
        if (lk.byte_stb) begin
            if (lk.byte_cnt == OPCODE_ONLY_BYTES) begin
                op_nxt = lk.byte_data;
            end else if (lk.byte_cnt <= ADDR_CMD_BYTES) begin
                adr_in_nxt = {adr_in_r[15:0], lk.byte_data};
            end
        end
        rd_nxt = lk.cs_low && (rd_r || (lk.byte_stb && lk.byte_cnt == OPCODE_ONLY_BYTES
                 && lk.byte_data == OP_READ_STATUS && !sleep_r
                 && state_r != ST_SLEEP_ENTRY));
        oe_nxt = rd_nxt;
        // Live status reloads at every byte so polling sees the busy flag drop
        if (rd_r && lk.sclk_fall) begin
            if (lk.bit_cnt == 3'h0) begin
                {so_nxt, sh_nxt} = status_byte;
            end else begin
                {so_nxt, sh_nxt} = {sh_r, 1'b0};
            end
        end
        case (state_r)
            ST_ERASING: begin
                // busy clears when the timer expires
                if (cnt_r == 32'h0) begin
                    state_nxt = ST_STANDBY;
                    busy_nxt  = 1'b0;
                    kind_nxt  = EK_NONE;
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            ST_SLEEP_ENTRY: begin
                // sleep takes effect after the entry delay
                if (cnt_r == 32'h0) begin
                    state_nxt = ST_SLEEP;
                    sleep_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 32'h1;
                end
            end
            default: begin
            end
        endcase
        // frames ending mid-byte are discarded here
        if (valid_end && lk.byte_cnt != 3'h0) begin
            arm_nxt = (op_r == OP_RESET_ENABLE) && (lk.byte_cnt == OPCODE_ONLY_BYTES);
            case (state_r)
                ST_STANDBY: begin
                    if (lk.byte_cnt == OPCODE_ONLY_BYTES) begin
                        if (op_r == OP_WRITE_ENABLE) begin
                            wen_nxt = 1'b1;
                        end else if (op_r == OP_WRITE_DISABLE || (op_r == OP_RESET && arm_r)) begin
                            wen_nxt = 1'b0;
                        end else if ((op_r == OP_CHIP_ERASE_A || op_r == OP_CHIP_ERASE_B)
                                     && wen_r && chip_ok) begin
                            state_nxt = ST_ERASING;
                            kind_nxt  = EK_CHIP;
                            addr_nxt  = 24'h000000;
                            cnt_nxt   = 32'(CHIP_ERASE_CYC - 1);
                            busy_nxt  = 1'b1;
                            // latch cleared at the start of the cycle
                            wen_nxt   = 1'b0;
                        end else if (op_r == OP_DEEP_SLEEP) begin
                            // sleep entry only through this command
                            state_nxt = ST_SLEEP_ENTRY;
                            cnt_nxt   = 32'(SLEEP_ENTRY_CYCLES - 1);
                        end
                    end else if (lk.byte_cnt == ADDR_CMD_BYTES && is_block_op && wen_r
                                 && !blk_prot) begin
                        // 32KB block erase, low address bits ignored
                        // 64KB block erase, low address bits ignored
                        state_nxt = ST_ERASING;
                        kind_nxt  = (op_r == OP_ERASE_32K) ? EK_BLOCK32 : EK_BLOCK64;
                        addr_nxt  = adr_in_r & ((op_r == OP_ERASE_32K) ? ERASE_32K_MASK
                                                                        : ERASE_64K_MASK);
                        cnt_nxt   = 32'(BLOCK_ERASE_CYC - 1);
                        busy_nxt  = 1'b1;
                        wen_nxt   = 1'b0;
                    end
                end
                ST_SLEEP: begin
                    // only wake or the reset pair are obeyed
                    if (op_r == OP_WAKE_READ_ID || (op_r == OP_RESET && arm_r)) begin
                        state_nxt = ST_STANDBY;
                        sleep_nxt = 1'b0;
                        wen_nxt   = (op_r == OP_RESET) ? 1'b0 : wen_r;
                    end
                end
                default: begin
                    // erasing or entering sleep, everything including sleep is refused
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r  <= ST_STANDBY;
            kind_r   <= EK_NONE;
            cnt_r    <= 32'h0;
            addr_r   <= 24'h000000;
            adr_in_r <= 24'h000000;
            op_r     <= 8'h00;
            sh_r     <= 7'h00;
            so_r     <= 1'b0;
            oe_r     <= 1'b0;
            rd_r     <= 1'b0;
            busy_r   <= 1'b0;
            wen_r    <= 1'b0;
            sleep_r  <= 1'b0;
            arm_r    <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            kind_r   <= kind_nxt;
            cnt_r    <= cnt_nxt;
            addr_r   <= addr_nxt;
            adr_in_r <= adr_in_nxt;
            op_r     <= op_nxt;
            sh_r     <= sh_nxt;
            so_r     <= so_nxt;
            oe_r     <= oe_nxt;
            rd_r     <= rd_nxt;
            busy_r   <= busy_nxt;
            wen_r    <= wen_nxt;
            sleep_r  <= sleep_nxt;
            arm_r    <= arm_nxt;
        end
    end

    assign so                     = so_r;
    assign so_oe                  = oe_r;
    assign write_in_progress_flag = busy_r;
    assign write_enable_latch     = wen_r;
    assign deep_sleep             = sleep_r;
    assign erase_kind             = kind_r;
    assign erase_addr             = addr_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_block_cmd;
        valid_end && state_r == ST_STANDBY && lk.byte_cnt == ADDR_CMD_BYTES && is_block_op;
    endsequence
    sequence s_sleep_cmd;
        valid_end && state_r == ST_STANDBY && lk.byte_cnt == OPCODE_ONLY_BYTES
        && op_r == OP_DEEP_SLEEP;
    endsequence
    sequence s_wake_cmd;
        valid_end && state_r == ST_SLEEP && lk.byte_cnt != 3'h0 && op_r == OP_WAKE_READ_ID;
    endsequence

    a_erase32_start: assert property (
        s_block_cmd and (op_r == OP_ERASE_32K && wen_r && !blk_prot)
        |=> busy_r && kind_r == EK_BLOCK32 && addr_r == ($past(adr_in_r) & ERASE_32K_MASK))
        else $error("32KB erase did not start");
    a_erase64_start: assert property (
        s_block_cmd and (op_r == OP_ERASE_64K && wen_r && !blk_prot)
        |=> busy_r && kind_r == EK_BLOCK64 && addr_r == ($past(adr_in_r) & ERASE_64K_MASK))
        else $error("64KB erase did not start");
    a_erase_needs_latch: assert property ($rose(busy_r) |-> $past(wen_r))
        else $error("erase started without write enable");
    a_torn_frame: assert property (
        lk.cs_rise && lk.bit_cnt != 3'h0 && state_r == ST_STANDBY
        |=> !busy_r && state_r == ST_STANDBY && $stable(wen_r))
        else $error("torn frame was executed");
    a_busy_release: assert property (
        state_r == ST_ERASING && cnt_r == 32'h0 |=> !busy_r && state_r == ST_STANDBY)
        else $error("busy flag did not clear at end");
    a_status_shift: assert property (
        rd_r && lk.sclk_fall && lk.bit_cnt == 3'h0 |=> {so, sh_r} == $past(status_byte))
        else $error("status byte not driven");
    a_latch_dropped: assert property (busy_r |-> !wen_r)
        else $error("write enable set during erase");
    a_block_protect: assert property (s_block_cmd and blk_prot |=> !busy_r)
        else $error("protected block erased");
    a_chip_gate: assert property ($rose(busy_r) && kind_r == EK_CHIP |-> $past(chip_ok))
        else $error("chip erase with protection set");
    a_sleep_entry: assert property (s_sleep_cmd |-> ##75 !sleep_r ##1 sleep_r)
        else $error("sleep not entered in time");
    a_wake: assert property (s_wake_cmd |=> !sleep_r && state_r == ST_STANDBY)
        else $error("wake command ignored");
    a_busy_refuse: assert property (state_r == ST_ERASING && cnt_r != 32'h0 && valid_end
        |=> state_r == ST_ERASING && !sleep_r)
        else $error("busy cycle disturbed");
    a_sleep_source: assert property ($rose(sleep_r) |-> $past(state_r) == ST_SLEEP_ENTRY)
        else $error("sleep entered without command");
endmodule

// *** hdl/sfe_link_rx.sv ***
// Pin synchroniser, serial clock edge finder and byte assembler
`timescale 1ns/10ps
module sfe_link_rx
    import sfe_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Pins
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic si,
    // Decoded events
    sfe_link_if.rx    lk
);
    logic       cs_s1_r, cs_s2_r, cs_prev_r, sclk_s1_r, sclk_s2_r, sclk_prev_r;
    logic       si_s1_r, si_s2_r;
    logic       rise_r, rise_nxt, fall_r, fall_nxt, stb_r, stb_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [2:0] bit_r, bit_nxt, byte_r, byte_nxt;

    always_comb begin
        rise_nxt = cs_s2_r && !cs_prev_r;
        fall_nxt = !sclk_s2_r && sclk_prev_r && !cs_s2_r;
        stb_nxt  = 1'b0;
        sh_nxt   = sh_r;
        bit_nxt  = bit_r;
        byte_nxt = byte_r;
        // Counters clear a cycle after the rise so the core sees the frame length with it
        if (cs_prev_r) begin
            bit_nxt  = 3'h0;
            byte_nxt = 3'h0;
        end else if (sclk_s2_r && !sclk_prev_r && !cs_s2_r) begin
            sh_nxt  = {sh_r[6:0], si_s2_r};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
                stb_nxt  = 1'b1;
                byte_nxt = (byte_r == 3'h7) ? byte_r : byte_r + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cs_s1_r     <= 1'b1;
            cs_s2_r     <= 1'b1;
            cs_prev_r   <= 1'b1;
            sclk_s1_r   <= 1'b0;
            sclk_s2_r   <= 1'b0;
            sclk_prev_r <= 1'b0;
            si_s1_r     <= 1'b0;
            si_s2_r     <= 1'b0;
            rise_r      <= 1'b0;
            fall_r      <= 1'b0;
            stb_r       <= 1'b0;
            sh_r        <= 8'h00;
            bit_r       <= 3'h0;
            byte_r      <= 3'h0;
        end else begin
            cs_s1_r     <= cs_n;
            cs_s2_r     <= cs_s1_r;
            cs_prev_r   <= cs_s2_r;
            sclk_s1_r   <= sclk;
            sclk_s2_r   <= sclk_s1_r;
            sclk_prev_r <= sclk_s2_r;
            si_s1_r     <= si;
            si_s2_r     <= si_s1_r;
            rise_r      <= rise_nxt;
            fall_r      <= fall_nxt;
            stb_r       <= stb_nxt;
            sh_r        <= sh_nxt;
            bit_r       <= bit_nxt;
            byte_r      <= byte_nxt;
        end
    end

    assign lk.cs_low    = !cs_prev_r;
    assign lk.cs_rise   = rise_r;
    assign lk.sclk_fall = fall_r;
    assign lk.byte_stb  = stb_r;
    assign lk.byte_data = sh_r;
    assign lk.byte_cnt  = byte_r;
    assign lk.bit_cnt   = bit_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_byte_strobe_align: assert property (
        lk.byte_stb |-> lk.bit_cnt == 3'h0 && lk.byte_cnt != 3'h0)
        else $error("byte strobe off a byte boundary");
endmodule

// *** shared/sfe_link_if.sv ***
// Decoded serial link events passed from the pin receiver to the command core
`timescale 1ns/10ps
interface sfe_link_if;
    logic       cs_low;
    logic       cs_rise;
    logic       sclk_fall;
    logic       byte_stb;
    logic [7:0] byte_data;
    logic [2:0] byte_cnt;
    logic [2:0] bit_cnt;

    modport rx   (output cs_low, cs_rise, sclk_fall, byte_stb, byte_data, byte_cnt, bit_cnt);
    modport core (input  cs_low, cs_rise, sclk_fall, byte_stb, byte_data, byte_cnt, bit_cnt);
endinterface

// *** shared/sfe_pkg.sv ***
// Constants, types and helper functions for the serial flash erase and sleep block
package sfe_pkg;
    // Opcodes
    localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS   = 8'h05;
    localparam logic [7:0] OP_ERASE_32K     = 8'h52;
    localparam logic [7:0] OP_ERASE_64K     = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hc7;
    localparam logic [7:0] OP_DEEP_SLEEP    = 8'hb9;
    localparam logic [7:0] OP_WAKE_READ_ID  = 8'hab;
    localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
    localparam logic [7:0] OP_RESET         = 8'h99;

    // Frame lengths in whole bytes
    localparam logic [2:0] OPCODE_ONLY_BYTES = 3'h1;
    localparam logic [2:0] ADDR_CMD_BYTES    = 3'h4;

    // Status byte layout
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_WEN_BIT   = 1;
    localparam int ST_BP_LSB    = 2;
    localparam int ST_COMPL_BIT = 7;

    // Block address masks and array size in 64KB blocks
    localparam logic [23:0] ERASE_32K_MASK = 24'hff8000;
    localparam logic [23:0] ERASE_64K_MASK = 24'hff0000;
    localparam logic [4:0]  NUM_64K_BLOCKS = 5'h10;

    // Timing
    localparam int unsigned CLK_FREQ_MHZ         = 25;
    localparam int unsigned BLOCK_ERASE_TIME_US  = 100000;
    localparam int unsigned ARRAY_ERASE_TIME_US  = 1000000;
    localparam int unsigned SLEEP_ENTRY_TIME_NS  = 3000;
    localparam int unsigned BLOCK_ERASE_CYCLES   = BLOCK_ERASE_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned ARRAY_ERASE_CYCLES   = ARRAY_ERASE_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned SLEEP_ENTRY_CYCLES   =
        (SLEEP_ENTRY_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

    typedef enum logic [1:0] {EK_NONE, EK_BLOCK32, EK_BLOCK64, EK_CHIP} sfe_erase_t;
    typedef enum logic [1:0] {ST_STANDBY, ST_ERASING, ST_SLEEP_ENTRY, ST_SLEEP} sfe_state_t;

    // Protected span grows from the top (bit 3 clear) or bottom (bit 3 set) of the array
    function automatic logic sfe_blk_protected(input logic [3:0] blk,
                                               input logic [4:0] bp,
                                               input logic       compl);
        logic [4:0] span;
        logic       hit;
        span = (bp[2:0] == 3'h0) ? 5'h00 :
               (bp[2:0] == 3'h7) ? NUM_64K_BLOCKS : (5'h01 << (bp[2:0] - 3'h1));
        hit  = bp[3] ? ({1'b0, blk} < span) : ({1'b0, blk} >= (NUM_64K_BLOCKS - span));
        return hit ^ compl;
    endfunction

    function automatic logic sfe_chip_erase_ok(input logic [4:0] bp, input logic compl);
        return ((bp[2:0] == 3'h0) && !compl) || ((bp[2:0] == 3'h7) && compl);
    endfunction
endpackage

// *** tb/sfe_bench.sv ***
// Self-checking bench for the erase and deep power-down command core
`timescale 1ns/10ps
module sfe_bench;
    import sfe_pkg::*;
    localparam int unsigned BLK_CYC  = 200;
    localparam int unsigned CHIP_CYC = 400;

    logic        ref_clk;
    logic        rst;
    logic        cs_n, sclk, si, so, so_oe;
    logic [4:0]  protect_bits;
    logic        protect_complement_bit;
    logic        write_in_progress_flag, write_enable_latch, deep_sleep;
    sfe_erase_t  erase_kind;
    logic [23:0] erase_addr;
    int          error_cnt;
    int          n_compared;

    sfe_host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));

    sfe_core #(.BLOCK_ERASE_CYC(BLK_CYC), .CHIP_ERASE_CYC(CHIP_CYC)) uut (
        .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
        .so_oe(so_oe), .protect_bits(protect_bits),
        .protect_complement_bit(protect_complement_bit),
        .write_in_progress_flag(write_in_progress_flag),
        .write_enable_latch(write_enable_latch), .deep_sleep(deep_sleep),
        .erase_kind(erase_kind), .erase_addr(erase_addr));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic erase_refused(input logic [7:0] op, input int nb, input logic write_enable_cmd);
        if (write_enable_cmd) begin
            host.frame({OP_WRITE_ENABLE, 24'h0}, 8);
        end
        host.frame({op, 24'h0f1234}, nb);
        check(write_in_progress_flag, 1'b0);
    endtask

    task automatic erase_ok(input logic [7:0] op, input int nb, input sfe_erase_t k,
                            input logic [23:0] a, input logic [23:0] base, input int dur);
        time t0;
        int  n;
        int  c;
        host.frame({OP_WRITE_ENABLE, 24'h0}, 8);
        check(write_enable_latch, 1'b1);
        host.frame({op, a}, nb);
        t0 = $time;
        check(write_in_progress_flag, 1'b1);
        check(write_enable_latch, 1'b0);
        check(erase_kind, k);
        check(erase_addr, base);
        host.frame({OP_READ_STATUS, 24'h0}, 16);
        check(host.rd_byte, {protect_complement_bit, protect_bits, 2'b01});
        if (k == EK_CHIP) begin
            host.frame({OP_DEEP_SLEEP, 24'h0}, 8);
            repeat (100) @(negedge ref_clk);
            check({deep_sleep, write_in_progress_flag}, 2'b01);
        end
        n = 0;
        while (write_in_progress_flag !== 1'b0 && n < dur + 50) begin
            @(negedge ref_clk);
            n++;
        end
        c = int'(($time - t0) / 40) + 10;
        check(c >= dur && c <= dur + 10, 1'b1);
        check(erase_kind, EK_NONE);
    endtask

    task automatic t_reset();
        check({write_in_progress_flag, write_enable_latch, deep_sleep, so_oe}, 4'h0);
        check(erase_kind, EK_NONE);
        $display("Test reset state done");
    endtask

    task automatic t_block();
        erase_refused(OP_ERASE_32K, 32, 1'b0);
        erase_refused(OP_ERASE_32K, 31, 1'b1);
        erase_ok(OP_ERASE_32K, 32, EK_BLOCK32, 24'h0abcde, 24'h0a8000, BLK_CYC);
        erase_ok(OP_ERASE_64K, 32, EK_BLOCK64, 24'h05ffff, 24'h050000, BLK_CYC);
        $display("Test block erase done");
    endtask

    task automatic t_protect();
        protect_bits = 5'h01;
        erase_refused(OP_ERASE_64K, 32, 1'b1);
        erase_refused(OP_CHIP_ERASE_B, 8, 1'b1);
        erase_ok(OP_ERASE_64K, 32, EK_BLOCK64, 24'h000010, 24'h000000, BLK_CYC);
        protect_bits = 5'h07;
        protect_complement_bit = 1'b1;
        erase_ok(OP_CHIP_ERASE_B, 8, EK_CHIP, 24'h0, 24'h0, CHIP_CYC);
        protect_bits = 5'h00;
        protect_complement_bit = 1'b0;
        erase_refused(OP_CHIP_ERASE_A, 9, 1'b1);
        erase_ok(OP_CHIP_ERASE_A, 8, EK_CHIP, 24'h0, 24'h0, CHIP_CYC);
        $display("Test protection and chip erase done");
    endtask

    task automatic t_sleep();
        host.frame({OP_WRITE_DISABLE, 24'h0}, 8);
        host.frame({OP_DEEP_SLEEP, 24'h0}, 8);
        repeat (60) @(negedge ref_clk);
        check(deep_sleep, 1'b0);
        repeat (20) @(negedge ref_clk);
        check(deep_sleep, 1'b1);
        host.frame({OP_WRITE_ENABLE, 24'h0}, 8);
        check({deep_sleep, write_enable_latch}, 2'b10);
        host.frame({OP_WAKE_READ_ID, 24'h0}, 8);
        check(deep_sleep, 1'b0);
        host.frame({OP_DEEP_SLEEP, 24'h0}, 8);
        repeat (80) @(negedge ref_clk);
        host.frame({OP_RESET_ENABLE, 24'h0}, 8);
        check(deep_sleep, 1'b1);
        host.frame({OP_RESET, 24'h0}, 8);
        check(deep_sleep, 1'b0);
        $display("Test deep sleep done");
    endtask

    initial begin
        rst = 1'b1;
        protect_bits = 5'h00;
        protect_complement_bit = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_block();
        t_protect();
        t_sleep();
        end_of_test();
    end

    // Whole sequence needs about 4700 cycles
    initial begin
        #(40 * 20000);
        error_cnt++;
        $display("Watchdog expired");
        end_of_test();
    end
endmodule

// *** tb/sfe_host_model.sv ***
// Serial link host model that frames commands and samples the status byte
`timescale 1ns/10ps
module sfe_host_model (
    // Clock
    input  wire logic ref_clk,
    // Link pins
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    input  wire logic so
);
    logic [7:0] rd_byte;

    initial begin
        cs_n    = 1'b1;
        sclk    = 1'b0;
        si      = 1'b0;
        rd_byte = 8'h00;
    end

    // Half of a 320 ns link clock period
    task automatic half_wait();
        repeat (4) @(negedge ref_clk);
    endtask

    // select held low for the frame, raised only after the last bit
    task automatic frame(input logic [31:0] data, input int nbits);
        @(negedge ref_clk);
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si = data[31 - i];
            half_wait();
            sclk = 1'b1;
            half_wait();
            // Sampled late in the high phase, well after the device moved so
            rd_byte = {rd_byte[6:0], so};
            sclk = 1'b0;
        end
        half_wait();
        cs_n = 1'b1;
        // Released line must not keep showing the last bit
        si = ~si;
        repeat (10) @(negedge ref_clk);
    endtask
endmodule
